// ==== hdl/udc_pkg.sv ====
// Purpose : shared constants of the up/down threshold counter
// Assumes : 40 MHz clock, 32-bit classic Wishbone register port
// Notes   : offsets are byte addresses of aligned 32-bit words
package udc_pkg;
  // ------------------------------------------------------------
  // count range
  // ------------------------------------------------------------
  localparam int             CW      = 20;
  localparam logic [CW-1:0]  CNT_MAX = 20'hF423F;
  localparam logic [CW-1:0]  CNT_MIN = 20'h00000;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ON     = 8'h04;
  localparam logic [7:0] OFS_OFF    = 8'h08;
  localparam logic [7:0] OFS_INIT   = 8'h0C;
  localparam logic [7:0] OFS_SCAN   = 8'h10;
  localparam logic [7:0] OFS_COUNT  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_ON_SRC  = 0;
  localparam int CTRL_OFF_SRC = 1;
  localparam int CTRL_RETAIN  = 2;
  localparam int STAT_SWITCH  = 0;
  localparam int STAT_CLR     = 1;
  localparam int STAT_RETAIN  = 2;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0]    CTRL_RST = 3'h0;
  localparam logic [CW-1:0] ON_RST   = 20'h00000;
  localparam logic [CW-1:0] OFF_RST  = 20'h00000;
  localparam logic [CW-1:0] INIT_RST = 20'h00000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          SCAN_TIME_NS  = 10000;
  localparam logic [15:0] SCAN_CYC      = 16'(SCAN_TIME_NS / CLK_PERIOD_NS);
endpackage

// ==== hdl/udc_sync.sv ====
// Purpose : two-flop synchronisers with rising edge detection
// Assumes : inputs come from outside the clock domain
// Notes   : edge compares the synced level with the previous sample
`timescale 1ns/100ps
module udc_sync import udc_pkg::*; #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] async_i,
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] rise_o
);
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;

  // ------------------------------------------------------------
  // per-bit synchroniser
  // ------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta[i] <= 1'b0;
        sync[i] <= 1'b0;
        prev[i] <= 1'b0;
      end else begin
        meta[i] <= async_i[i];
        sync[i] <= meta[i];
        prev[i] <= sync[i];
      end
    end
    assign level_o[i] = sync[i];
    assign rise_o[i]  = sync[i] & ~prev[i]; // R13
  end
endmodule

// ==== hdl/udc_clamp.sv ====
// Purpose : threshold source select with range clamp
// Assumes : referenced value is a signed word on the same clock
// Notes   : combinational
`timescale 1ns/100ps
module udc_clamp import udc_pkg::*; (
  input  wire logic               sel_ref_i,
  input  wire logic [CW-1:0]      const_i,
  input  wire logic signed [31:0] ref_i,
  output logic        [CW-1:0]    val_o
);
  always_comb begin
    if (!sel_ref_i) begin
      val_o = const_i;
    end else if (ref_i < 0) begin
      val_o = CNT_MIN; // R09
    end else if (ref_i > $signed({12'h000, CNT_MAX})) begin
      val_o = CNT_MAX; // R09
    end else begin
      val_o = ref_i[CW-1:0]; // R08
    end
  end
endmodule

// ==== hdl/udc_top.sv ====
// Purpose : up/down event counter with on/off threshold output
// Assumes : classic Wishbone slave, 32-bit data, one cycle answer
// Notes   : comparisons happen once per scan tick only
`timescale 1ns/100ps
// Contract
// R01 - each rising pulse edge moves count by one
// R02 - direction low counts up, high counts down
// R03 - clear input loads count with start value
// R04 - while clear high: output low, edges dropped
// R05 - start value is software configurable
// R06 - on>=off: hysteresis set at on, clear below off
// R07 - on<off: output high inside window only
// R08 - thresholds may come from another block
// R09 - referenced thresholds clamp to valid range
// R10 - retention off: power loss clears count, output
// R11 - compare only once per scan cycle
// R12 - window skipped between scans leaves output
// R13 - edge by sample compare; count holds 999999
module udc_top import udc_pkg::*; (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic [3:0]         sel_i,
  input  wire logic               we_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic               cnt_pulse_i,
  input  wire logic               cnt_dir_i,
  input  wire logic               cnt_clr_i,
  input  wire logic               pwr_lost_i,
  input  wire logic signed [31:0] on_ref_i,
  input  wire logic signed [31:0] off_ref_i,
  output logic      [CW-1:0]      count_o,
  output logic                    switch_o
);
  logic [2:0]    ctrl;
  logic [CW-1:0] on_thresh;
  logic [CW-1:0] off_thresh;
  logic [CW-1:0] initial_count;
  logic [15:0]   scan_period;
  logic [15:0]   scan_cnt;
  logic          scan_tick;
  logic [CW-1:0] count;
  logic          switch_q;
  logic [CW-1:0] on_val;
  logic [CW-1:0] off_val;
  logic [3:0]    pin_lvl;
  logic [3:0]    pin_rise;
  logic          pulse_rise;
  logic          dir_lvl;
  logic          clr_lvl;
  logic          pwr_clear;
  logic          wr_en;
  logic          rd_req;
  logic [31:0]   next_rdata;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  udc_sync #(.N(4)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({pwr_lost_i, cnt_clr_i, cnt_dir_i, cnt_pulse_i}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise)
  );

  assign pulse_rise = pin_rise[0];
  assign dir_lvl    = pin_lvl[1];
  assign clr_lvl    = pin_lvl[2];
  assign pwr_clear  = pin_rise[3] & ~ctrl[CTRL_RETAIN]; // R10

  // ------------------------------------------------------------
  // threshold sources
  // ------------------------------------------------------------
  udc_clamp u_on (
    .sel_ref_i (ctrl[CTRL_ON_SRC]),
    .const_i   (on_thresh),
    .ref_i     (on_ref_i),
    .val_o     (on_val)
  );

  udc_clamp u_off (
    .sel_ref_i (ctrl[CTRL_OFF_SRC]),
    .const_i   (off_thresh),
    .ref_i     (off_ref_i),
    .val_o     (off_val)
  );

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wr_en  = cyc_i & stb_i & we_i & ack_o;
  assign rd_req = cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= rd_req;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (adr_i)
      OFS_CTRL:   next_rdata[2:0]    = ctrl;
      OFS_ON:     next_rdata[CW-1:0] = on_thresh;
      OFS_OFF:    next_rdata[CW-1:0] = off_thresh;
      OFS_INIT:   next_rdata[CW-1:0] = initial_count;
      OFS_SCAN:   next_rdata[15:0]   = scan_period;
      OFS_COUNT:  next_rdata[CW-1:0] = count;
      OFS_STATUS: begin
        next_rdata[STAT_SWITCH] = switch_q;
        next_rdata[STAT_CLR]    = clr_lvl;
        next_rdata[STAT_RETAIN] = ctrl[CTRL_RETAIN];
      end
      default:    next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd_req) begin
      dat_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && adr_i == OFS_CTRL) begin
      ctrl <= 3'(merge({29'h0, ctrl}, dat_i, sel_i)); // R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_thresh <= ON_RST;
    end else if (wr_en && adr_i == OFS_ON) begin
      on_thresh <= CW'(merge({12'h0, on_thresh}, dat_i, sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_thresh <= OFF_RST;
    end else if (wr_en && adr_i == OFS_OFF) begin
      off_thresh <= CW'(merge({12'h0, off_thresh}, dat_i, sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      initial_count <= INIT_RST;
    end else if (wr_en && adr_i == OFS_INIT) begin
      initial_count <= CW'(merge({12'h0, initial_count}, dat_i, sel_i)); // R05
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_period <= SCAN_CYC;
    end else if (wr_en && adr_i == OFS_SCAN) begin
      scan_period <= 16'(merge({16'h0, scan_period}, dat_i, sel_i));
    end
  end

  // ------------------------------------------------------------
  // scan timer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_cnt  <= SCAN_CYC;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (scan_cnt == 16'h0000); // R11
      if (scan_cnt == 16'h0000) begin
        scan_cnt <= (scan_period == 16'h0000) ? 16'h0000 : scan_period - 16'h0001;
      end else begin
        scan_cnt <= scan_cnt - 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= INIT_RST;
    end else if (clr_lvl) begin
      count <= initial_count; // R03 R04
    end else if (pwr_clear) begin
      count <= CNT_MIN; // R10
    end else if (pulse_rise) begin
      if (!dir_lvl && count != CNT_MAX) begin
        count <= count + 20'h00001; // R01 R02
      end else if (dir_lvl && count != CNT_MIN) begin
        count <= count - 20'h00001; // R01 R02
      end
    end
  end

  assign count_o = count;

  // ------------------------------------------------------------
  // switching output
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_q <= 1'b0;
    end else if (clr_lvl) begin
      switch_q <= 1'b0; // R04
    end else if (pwr_clear) begin
      switch_q <= 1'b0; // R10
    end else if (scan_tick) begin
      if (on_val >= off_val) begin
        if (count >= on_val) begin
          switch_q <= 1'b1; // R06
        end else if (count < off_val) begin
          switch_q <= 1'b0; // R06
        end
      end else begin
        switch_q <= (count >= on_val) && (count < off_val); // R07 R12
      end
    end
  end

  assign switch_o = switch_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_free;
    !clr_lvl && !pwr_clear;
  endsequence

  sequence s_up_edge;
    s_free ##0 pulse_rise && !dir_lvl && count != CNT_MAX;
  endsequence

  sequence s_dn_edge;
    s_free ##0 pulse_rise && dir_lvl && count != CNT_MIN;
  endsequence

  property p_count_up;
    s_up_edge |=> count == $past(count) + 20'h00001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("up edge not counted"); // R01

  property p_count_dn;
    s_dn_edge |=> count == $past(count) - 20'h00001;
  endproperty
  a_count_dn: assert property (p_count_dn) else $error("down edge not counted"); // R02

  property p_no_edge_hold;
    s_free ##0 !pulse_rise |=> $stable(count);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("count moved without edge"); // R01

  property p_clr_load;
    clr_lvl |=> count == $past(initial_count) && !switch_o;
  endproperty
  a_clr_load: assert property (p_clr_load) else $error("clear did not load start value"); // R03

  property p_clr_hold;
    clr_lvl [*3] |=> $stable(count) && !switch_o;
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("edge counted during clear"); // R04

  property p_hyst_set;
    s_free ##0 scan_tick && on_val >= off_val && count >= on_val |=> switch_o;
  endproperty
  a_hyst_set: assert property (p_hyst_set) else $error("hysteresis did not set"); // R06

  property p_hyst_clr;
    s_free ##0 scan_tick && on_val >= off_val && count < off_val |=> !switch_o;
  endproperty
  a_hyst_clr: assert property (p_hyst_clr) else $error("hysteresis did not clear"); // R06

  property p_window;
    s_free ##0 scan_tick && on_val < off_val
      |=> switch_o == ($past(count) >= $past(on_val) && $past(count) < $past(off_val));
  endproperty
  a_window: assert property (p_window) else $error("window output wrong"); // R07

  property p_scan_only;
    s_free ##0 !scan_tick |=> $stable(switch_o);
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("output changed off scan"); // R11

  property p_clamp;
    on_val <= CNT_MAX && off_val <= CNT_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("threshold out of range"); // R09

  property p_pwr_clear;
    pwr_clear && !clr_lvl |=> count == CNT_MIN && !switch_o;
  endproperty
  a_pwr_clear: assert property (p_pwr_clear) else $error("power loss did not clear"); // R10

  property p_pwr_keep;
    pin_rise[3] && ctrl[CTRL_RETAIN] && !clr_lvl && !pulse_rise |=> $stable(count);
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("retained count lost"); // R10
endmodule

// ==== dv/udc_pulse_src.sv ====
// Purpose : far-side pulse source feeding the counter input
// Assumes : high 3 cycles, low 3 cycles per pulse
// Notes   : idle level low, no edge outside a burst
`timescale 1ns/100ps
module udc_pulse_src (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n_i,
  output logic            pulse_o,
  output logic            busy_o
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph   = 3'h0;

  always @(posedge clk_i) begin
    if (go_i) begin
      left <= n_i;
      ph   <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      if (ph == 3'h5) begin
        left <= left - 8'h01;
      end
    end
  end
  assign pulse_o = (left != 8'h00) && (ph < 3'h3);
  assign busy_o  = (left != 8'h00);
endmodule

// ==== dv/up_down_threshold_counter_tb.sv ====
// Purpose : self-checking bench of the up/down threshold counter
// Assumes : scan period set to 4 cycles before threshold checks
// Notes   : fixed waits derive from the scan period and sync depth
`timescale 1ns/100ps
module up_down_threshold_counter_tb import udc_pkg::*;;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [7:0]         adr   = 8'h00;
  logic [31:0]        dat   = 32'h0;
  logic [31:0]        rdat;
  logic [3:0]         sel   = 4'h0;
  logic               we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic               dir = 1'b0, clr = 1'b0, pwr = 1'b0, go = 1'b0;
  logic [7:0]         npl   = 8'h00;
  logic signed [31:0] on_ref = 32'sh0, off_ref = 32'sh0;
  logic [31:0]        dat_o;
  logic               ack_o, pulse, busy, switch_o;
  logic [CW-1:0]      count_o;
  int                 fails = 0, cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  udc_top udc_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dat_o),
    .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .cnt_pulse_i(pulse),
    .cnt_dir_i(dir), .cnt_clr_i(clr), .pwr_lost_i(pwr), .on_ref_i(on_ref),
    .off_ref_i(off_ref), .count_o(count_o), .switch_o(switch_o));
  udc_pulse_src udc_pulse_src_i (.clk_i(clk_i), .go_i(go), .n_i(npl), .pulse_o(pulse),
    .busy_o(busy));

  task summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fails++;
      summarize();
    end
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(name, rdat, exp);
  endtask

  // sends n pulses in the given direction and lets the count settle
  task pulses(input logic [7:0] n, input logic d);
    int k;
    @(posedge clk_i);
    dir <= d; npl <= n; go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy && k < 4000);
    if (busy) begin
      fails++;
      summarize();
    end
    repeat (8) @(posedge clk_i);
  endtask

  task state(input logic [CW-1:0] c, input logic s);
    repeat (15) @(posedge clk_i);
    chk("count", 32'(count_o), 32'(c));
    chk("switch", 32'(switch_o), 32'(s));
  endtask

  task t_regs();
    rchk("ctrl", OFS_CTRL, 32'(CTRL_RST));
    rchk("on", OFS_ON, 32'(ON_RST));
    rchk("off", OFS_OFF, 32'(OFF_RST));
    rchk("init", OFS_INIT, 32'(INIT_RST));
    rchk("scan", OFS_SCAN, 32'(SCAN_CYC));
    wb(1'b1, OFS_COUNT, 32'h0000_0077);
    rchk("count_ro", OFS_COUNT, 32'h0);
    rchk("unmapped", 8'h1C, 32'h0);
  endtask

  task t_clear();
    wb(1'b1, OFS_SCAN, 32'h4);
    // the countdown loaded at reset must expire before the short period applies
    repeat (int'(SCAN_CYC)) @(posedge clk_i);
    wb(1'b1, OFS_INIT, 32'h5);
    @(posedge clk_i);
    clr <= 1'b1;
    pulses(8'h3, 1'b0);
    state(20'h5, 1'b0);
    rchk("status", OFS_STATUS, 32'h2);
    @(posedge clk_i);
    clr <= 1'b0;
    state(20'h5, 1'b1);
  endtask

  task t_power(input logic [CW-1:0] c, input logic s);
    @(posedge clk_i);
    pwr <= 1'b1;
    repeat (6) @(posedge clk_i);
    pwr <= 1'b0;
    state(c, s);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_clear();
    pulses(8'h3, 1'b0);
    state(20'h8, 1'b1);
    pulses(8'h2, 1'b1);
    state(20'h6, 1'b1);
    wb(1'b1, OFS_ON, 32'h8);
    wb(1'b1, OFS_OFF, 32'h6);
    t_power(20'h0, 1'b0);
    pulses(8'h7, 1'b0);
    state(20'h7, 1'b0);
    pulses(8'h1, 1'b0);
    state(20'h8, 1'b1);
    pulses(8'h1, 1'b1);
    state(20'h7, 1'b1);
    pulses(8'h2, 1'b1);
    state(20'h5, 1'b0);
    wb(1'b1, OFS_CTRL, 32'h4);
    pulses(8'h3, 1'b0);
    t_power(20'h8, 1'b1);
    rchk("status", OFS_STATUS, 32'h5);
    wb(1'b1, OFS_ON, 32'hA);
    wb(1'b1, OFS_OFF, 32'hC);
    state(20'h8, 1'b0);
    pulses(8'h2, 1'b0);
    state(20'hA, 1'b1);
    pulses(8'h2, 1'b0);
    state(20'hC, 1'b0);
    on_ref  <= -32'sd7;
    off_ref <= 32'sd2000000;
    wb(1'b1, OFS_CTRL, 32'h3);
    state(20'hC, 1'b1);
    rchk("status", OFS_STATUS, 32'h1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule
